// ### ebf_pkg.sv
// Constants, modes and shared decode for the block RAM with FIFO mode.
package ebf_pkg;

   // Array capacity: parity-capable widths see the full array, the others a power of two.
   localparam int EBF_TOTAL_BITS  = 9216;
   localparam int EBF_BINARY_BITS = 8192;
   localparam int EBF_PARITY_UNIT = 9;

   // Default port widths.
   localparam int EBF_WIDTH_A = 9;
   localparam int EBF_WIDTH_B = 9;

   // Widths on which read-before-write exists.
   localparam int EBF_RBW_W9  = 9;
   localparam int EBF_RBW_W18 = 18;
   localparam int EBF_RBW_W36 = 36;

   // Flag values after reset and the fixed empty level.
   localparam logic EBF_FULL_RST         = 1'b0;
   localparam logic EBF_ALMOST_FULL_RST  = 1'b0;
   localparam logic EBF_ALMOST_EMPTY_RST = 1'b1;
   localparam logic EBF_EMPTY_RST        = 1'b1;
   localparam int   EBF_EMPTY_LEVEL      = 0;

   typedef enum logic [1:0] {
      EBF_WM_NORMAL,
      EBF_WM_THROUGH,
      EBF_WM_READ_BEFORE
   } ebf_wmode_t;

   function automatic int ebf_depth(input int w);
      return (w % EBF_PARITY_UNIT == 0) ? EBF_TOTAL_BITS / w : EBF_BINARY_BITS / w;
   endfunction

   function automatic logic ebf_rbw_ok(input int w);
      return (w == EBF_RBW_W9) || (w == EBF_RBW_W18) || (w == EBF_RBW_W36);
   endfunction

   // Returns {load, take_write_data} for one registered port access.
   function automatic logic [1:0] ebf_port_load(input logic rd, input logic wr,
                                                input ebf_wmode_t mode, input int w);
      logic [1:0] res;
      res = 2'h0;
      if (rd) begin
         res = 2'h2;
      end else if (wr) begin
         unique case (mode)
            EBF_WM_NORMAL:      res = 2'h0;
            EBF_WM_THROUGH:     res = 2'h3;
            EBF_WM_READ_BEFORE: res = ebf_rbw_ok(w) ? 2'h2 : 2'h0;
            default:            res = 2'h0;
         endcase
      end
      return res;
   endfunction

endpackage

// ### ebf_lat_if.sv
// Interface between the array core and one port's output latch stage.
`timescale 1ns/1ps
interface ebf_lat_if #(
   parameter int W = 9
);
   logic         load;
   logic [W-1:0] d;
   logic         clr;
   logic         reg_en;
   logic [W-1:0] q;

   modport core  (output load, output d, output clr, output reg_en, input q);
   modport latch (input load, input d, input clr, input reg_en, output q);
endinterface

// ### ebf_out_latch.sv
// Output latch and optional output register of one array port.
`timescale 1ns/1ps
module ebf_out_latch #(
   parameter int W = 9
) (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic resetn_i,
   // Core side
   ebf_lat_if.latch  lat
);

   logic [W-1:0] latch_reg;
   logic [W-1:0] pipe_reg;

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || lat.clr) begin
         latch_reg <= '0;
      end else if (lat.load) begin
         latch_reg <= lat.d;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || lat.clr) begin
         pipe_reg <= '0;
      end else begin
         pipe_reg <= latch_reg;
      end
   end

   // The clear masks the output at once, so it acts without waiting for an edge;
   // the flops are also cleared so the output stays zero after release.
   assign lat.q = lat.clr ? '0 : (lat.reg_en ? pipe_reg : latch_reg);

   a_clear_async: assert property (@(posedge clk_sys_i) lat.clr |-> lat.q == '0)
      else $error("output not zero while its clear is active");

   a_clear_holds: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      lat.clr ##1 (!lat.clr && !lat.load) |-> lat.q == '0)
      else $error("output not held at zero after clear");

endmodule

// ### ebf_block_ram_fifo.sv
// Dual-port block RAM with selectable write behaviour and a FIFO mode.
`timescale 1ns/1ps
module ebf_block_ram_fifo
   import ebf_pkg::*;
#(
   parameter int WA  = EBF_WIDTH_A,
   parameter int WB  = EBF_WIDTH_B,
   localparam int AWA = $clog2(ebf_depth(WA)),
   localparam int AWB = $clog2(ebf_depth(WB)),
   localparam int PW  = AWA + 1
) (
   // Clock and resets
   input  wire logic           clk_sys_i,
   input  wire logic           resetn_i,
   input  wire logic           global_set_reset_n_i,
   // Configuration
   input  wire logic           fifo_mode_i,
   input  wire logic           out_reg_en_i,
   input  wire logic [1:0]     a_write_mode_i,
   input  wire logic [1:0]     b_write_mode_i,
   // Port A
   input  wire logic           a_clock_enable_i,
   input  wire logic           a_write_enable_i,
   input  wire logic [AWA-1:0] a_addr_i,
   input  wire logic [WA-1:0]  a_data_i,
   input  wire logic           port_a_reset_i,
   output logic      [WA-1:0]  a_data_o,
   // Port B
   input  wire logic           b_clock_enable_i,
   input  wire logic           b_write_enable_i,
   input  wire logic [AWB-1:0] b_addr_i,
   input  wire logic [WB-1:0]  b_data_i,
   input  wire logic           port_b_reset_i,
   output logic      [WB-1:0]  b_data_o,
   // FIFO control and thresholds
   input  wire logic           write_clock_enable_i,
   input  wire logic           write_enable_i,
   input  wire logic           read_clock_enable_i,
   input  wire logic           pop_strobe_i,
   input  wire logic [AWA-1:0] full_level_i,
   input  wire logic [AWA-1:0] almost_full_level_i,
   input  wire logic [AWA-1:0] almost_empty_level_i,
   // FIFO flags
   output logic                full_flag_o,
   output logic                almost_full_flag_o,
   output logic                almost_empty_flag_o,
   output logic                empty_flag_o
);

   localparam int DEPTH_A = ebf_depth(WA);
   localparam int DEPTH_B = ebf_depth(WB);

   logic [EBF_TOTAL_BITS-1:0] mem_reg;

   logic           a_ce_reg;
   logic           a_we_reg;
   logic [AWA-1:0] a_addr_reg;
   logic [WA-1:0]  a_din_reg;
   logic           b_ce_reg;
   logic           b_we_reg;
   logic [AWB-1:0] b_addr_reg;
   logic [WB-1:0]  b_din_reg;

   logic [PW-1:0]  wptr_reg;
   logic [PW-1:0]  rptr_reg;
   logic [PW-1:0]  fill;
   logic           fifo_clear;
   logic           fifo_full_now;
   logic           fifo_wr;
   logic           fifo_rd;

   ebf_wmode_t     a_mode;
   ebf_wmode_t     b_mode;
   logic           a_wr;
   logic           a_rd;
   logic           b_wr;
   logic           b_rd;
   int             a_base;
   int             b_base;
   int             wr_base;
   int             rd_base;
   logic [WA-1:0]  a_old;
   logic [WB-1:0]  b_old;
   logic [WB-1:0]  fifo_word;
   logic [1:0]     a_ld;
   logic [1:0]     b_ld;

   ebf_lat_if #(.W(WA)) a_lat ();
   ebf_lat_if #(.W(WB)) b_lat ();

   assign a_mode = ebf_wmode_t'(a_write_mode_i);
   assign b_mode = ebf_wmode_t'(b_write_mode_i);

   // Port requests are captured here; the array is touched one cycle later.
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         a_ce_reg   <= 1'b0;
         a_we_reg   <= 1'b0;
         a_addr_reg <= '0;
         a_din_reg  <= '0;
      end else begin
         a_ce_reg   <= a_clock_enable_i & ~fifo_mode_i;
         a_we_reg   <= a_write_enable_i;
         a_addr_reg <= a_addr_i;
         a_din_reg  <= a_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         b_ce_reg   <= 1'b0;
         b_we_reg   <= 1'b0;
         b_addr_reg <= '0;
         b_din_reg  <= '0;
      end else begin
         b_ce_reg   <= b_clock_enable_i & ~fifo_mode_i;
         b_we_reg   <= b_write_enable_i;
         b_addr_reg <= b_addr_i;
         b_din_reg  <= b_data_i;
      end
   end

   // Addresses beyond the depth of a width are ignored rather than aliased.
   assign a_wr   = a_ce_reg & a_we_reg & (int'(a_addr_reg) < DEPTH_A);
   assign a_rd   = a_ce_reg & ~a_we_reg & (int'(a_addr_reg) < DEPTH_A);
   assign b_wr   = b_ce_reg & b_we_reg & (int'(b_addr_reg) < DEPTH_B);
   assign b_rd   = b_ce_reg & ~b_we_reg & (int'(b_addr_reg) < DEPTH_B);
   assign a_base = (int'(a_addr_reg) < DEPTH_A) ? int'(a_addr_reg) * WA : 0;
   assign b_base = (int'(b_addr_reg) < DEPTH_B) ? int'(b_addr_reg) * WB : 0;
   assign a_old  = mem_reg[a_base +: WA];
   assign b_old  = mem_reg[b_base +: WB];

   // FIFO words are WA bits; the read port must be given the same width.
   assign wr_base   = int'(wptr_reg[AWA-1:0]) * WA;
   assign rd_base   = int'(rptr_reg[AWA-1:0]) * WA;
   assign fifo_word = mem_reg[rd_base +: WB];

   assign fill          = wptr_reg - rptr_reg;
   assign fifo_clear    = fifo_mode_i & port_a_reset_i;
   assign fifo_full_now = fill >= {1'b0, full_level_i};
   assign fifo_wr       = fifo_mode_i & write_clock_enable_i & write_enable_i
                        & ~fifo_full_now & ~port_a_reset_i;
   assign fifo_rd       = fifo_mode_i & read_clock_enable_i & pop_strobe_i
                        & (fill != '0) & ~port_a_reset_i & ~port_b_reset_i;

   // Port B wins when both ports write the same bits in one cycle.
   always_ff @(posedge clk_sys_i) begin
      if (fifo_wr) begin
         mem_reg[wr_base +: WA] <= a_data_i;
      end
      if (a_wr) begin
         mem_reg[a_base +: WA] <= a_din_reg;
      end
      if (b_wr) begin
         mem_reg[b_base +: WB] <= b_din_reg;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || fifo_clear) begin
         wptr_reg <= '0;
      end else if (fifo_wr) begin
         wptr_reg <= wptr_reg + PW'(1);
      end
   end

   // A read-pointer reset replays whatever the write pointer has passed.
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || fifo_clear) begin
         rptr_reg <= '0;
      end else if (fifo_mode_i && port_b_reset_i) begin
         rptr_reg <= '0;
      end else if (fifo_rd) begin
         rptr_reg <= rptr_reg + PW'(1);
      end
   end

   // Both sides share the one system clock, so each flag is one register stage.
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || fifo_clear) begin
         full_flag_o        <= EBF_FULL_RST;
         almost_full_flag_o <= EBF_ALMOST_FULL_RST;
      end else begin
         full_flag_o        <= fill >= {1'b0, full_level_i};
         almost_full_flag_o <= fill >= {1'b0, almost_full_level_i};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || fifo_clear) begin
         almost_empty_flag_o <= EBF_ALMOST_EMPTY_RST;
         empty_flag_o        <= EBF_EMPTY_RST;
      end else begin
         almost_empty_flag_o <= fill <= {1'b0, almost_empty_level_i};
         empty_flag_o        <= fill == PW'(EBF_EMPTY_LEVEL);
      end
   end

   assign a_ld = ebf_port_load(a_rd, a_wr, a_mode, WA);
   assign b_ld = ebf_port_load(b_rd, b_wr, b_mode, WB);

   always_comb begin
      a_lat.load = a_ld[1];
      a_lat.d    = a_ld[0] ? a_din_reg : a_old;
   end

   always_comb begin
      if (fifo_rd) begin
         b_lat.load = 1'b1;
         b_lat.d    = fifo_word;
      end else begin
         b_lat.load = b_ld[1];
         b_lat.d    = b_ld[0] ? b_din_reg : b_old;
      end
   end

   assign a_lat.clr    = port_a_reset_i | ~global_set_reset_n_i;
   assign b_lat.clr    = port_b_reset_i | ~global_set_reset_n_i;
   assign a_lat.reg_en = out_reg_en_i;
   assign b_lat.reg_en = out_reg_en_i;

   ebf_out_latch #(.W(WA)) u_lat_a (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .lat       (a_lat)
   );

   ebf_out_latch #(.W(WB)) u_lat_b (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .lat       (b_lat)
   );

   assign a_data_o = a_lat.q;
   assign b_data_o = b_lat.q;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);

   a_normal_write_hold: assert property (
      a_wr && a_mode == EBF_WM_NORMAL && !out_reg_en_i
      |=> out_reg_en_i || a_lat.clr || $stable(a_data_o))
      else $error("normal write changed the port A output");

   a_write_through_copy: assert property (
      a_wr && a_mode == EBF_WM_THROUGH && !out_reg_en_i
      |=> out_reg_en_i || a_lat.clr || a_data_o == $past(a_din_reg))
      else $error("write-through did not show the written data");

   a_read_before_old: assert property (
      b_wr && b_mode == EBF_WM_READ_BEFORE && ebf_rbw_ok(WB) && !out_reg_en_i
      |=> out_reg_en_i || b_lat.clr || b_data_o == $past(b_old))
      else $error("read-before-write did not show the old word");

   a_full_flags_reg: assert property (
      !fifo_clear ##1 !$past(fifo_clear)
      |-> full_flag_o == ($past(fill) >= {1'b0, $past(full_level_i)})
       && almost_full_flag_o == ($past(fill) >= {1'b0, $past(almost_full_level_i)}))
      else $error("full flags disagree with previous fill");

   a_empty_flags_reg: assert property (
      !fifo_clear |=> empty_flag_o == ($past(fill) == '0)
       && almost_empty_flag_o == ($past(fill) <= {1'b0, $past(almost_empty_level_i)}))
      else $error("empty flags disagree with previous fill");

   a_global_fifo_clear: assert property (
      fifo_clear |=> fill == '0 && wptr_reg == '0 && empty_flag_o && almost_empty_flag_o
       && !full_flag_o && !almost_full_flag_o)
      else $error("port A reset did not clear the FIFO");

   a_retransmit_ptr: assert property (
      fifo_mode_i && port_b_reset_i && !port_a_reset_i
      |=> rptr_reg == '0 && wptr_reg == $past(wptr_reg) + PW'($past(fifo_wr)))
      else $error("port B reset did more than clear the read pointer");

   a_no_overflow: assert property (
      fifo_mode_i && fifo_full_now && !port_a_reset_i |=> $stable(wptr_reg))
      else $error("write pointer moved while full");

   a_no_underflow: assert property (
      fifo_mode_i && fill == '0 && !port_a_reset_i && !port_b_reset_i
      |=> $stable(rptr_reg))
      else $error("read pointer moved while empty");

   a_latch_clear_sel: assert property (
      port_a_reset_i && global_set_reset_n_i && !port_b_reset_i && !b_lat.load
      && !out_reg_en_i |=> port_b_reset_i || !global_set_reset_n_i || out_reg_en_i
      || $stable(b_data_o))
      else $error("port A reset disturbed port B output");

   a_global_latch_clear: assert property (
      !global_set_reset_n_i |-> a_data_o == '0 && b_data_o == '0)
      else $error("global reset did not clear both outputs");

endmodule

// ### ebf_fifo_user.sv
// Behavioural user logic that drives the FIFO write and read ports.
`timescale 1ns/1ps
module ebf_fifo_user (
   // Clock
   input  wire logic       clk_sys_i,
   // Read data from the block
   input  wire logic [8:0] rd_data_i,
   // Write port
   output logic            wr_clk_en_o,
   output logic            wr_en_o,
   output logic [8:0]      wr_data_o,
   // Read port
   output logic            rd_clk_en_o,
   output logic            pop_o
);
   logic [8:0] tx_q[$];
   logic [8:0] rx_q[$];

   initial begin
      wr_clk_en_o = 1'b0;
      wr_en_o     = 1'b0;
      wr_data_o   = 9'h0;
      rd_clk_en_o = 1'b0;
      pop_o       = 1'b0;
   end

   // Call just after a rising edge; returns at the edge that takes the last push.
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         wr_clk_en_o <= 1'b1;
         wr_en_o     <= 1'b1;
         wr_data_o   <= tx_q.pop_front();
         @(posedge clk_sys_i);
      end
      wr_clk_en_o <= 1'b0;
      wr_en_o     <= 1'b0;
      // Idle data is scrambled so a stale word can never pass for a fresh one.
      wr_data_o   <= ~wr_data_o;
   endtask

   // Pops back to back and logs every word, so retransmissions can be matched up.
   task automatic take(input int n);
      rd_clk_en_o <= 1'b1;
      pop_o       <= 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys_i);
         if (i == n - 1) begin
            rd_clk_en_o <= 1'b0;
            pop_o       <= 1'b0;
         end
         #1 rx_q.push_back(rd_data_i);
      end
   endtask
endmodule

// ### ebf_block_ram_fifo_test.sv
// Self-checking testbench for the block RAM with FIFO mode.
`timescale 1ns/1ps
module ebf_block_ram_fifo_test;
   logic       clk, rstn, gsr_n, fifo, oreg, ce_a, we_a, ce_b, we_b, pa_rst, pb_rst;
   logic [1:0] mode_a, mode_b;
   logic [9:0] ad_a, ad_b, adr, full_lvl, af_lvl, ae_lvl;
   logic [8:0] dat_a, dat_b, a_data_o, b_data_o, u_wdata, v0, v1, v2;
   logic [8:0] dat[6];
   wire  [8:0] a_in = fifo ? u_wdata : dat_a;
   logic       wce, wen, read_clock_enable, pop, ff, af, ae, ef;
   int         seed, fail_count, n_checks, cyc;

   ebf_block_ram_fifo uut (.clk_sys_i(clk), .resetn_i(rstn), .global_set_reset_n_i(gsr_n),
      .fifo_mode_i(fifo), .out_reg_en_i(oreg), .a_write_mode_i(mode_a),
      .b_write_mode_i(mode_b), .a_clock_enable_i(ce_a), .a_write_enable_i(we_a),
      .a_addr_i(ad_a), .a_data_i(a_in), .port_a_reset_i(pa_rst), .a_data_o(a_data_o),
      .b_clock_enable_i(ce_b), .b_write_enable_i(we_b), .b_addr_i(ad_b), .b_data_i(dat_b),
      .port_b_reset_i(pb_rst), .b_data_o(b_data_o), .write_clock_enable_i(wce),
      .write_enable_i(wen), .read_clock_enable_i(read_clock_enable), .pop_strobe_i(pop),
      .full_level_i(full_lvl), .almost_full_level_i(af_lvl),
      .almost_empty_level_i(ae_lvl), .full_flag_o(ff), .almost_full_flag_o(af),
      .almost_empty_flag_o(ae), .empty_flag_o(ef));

   ebf_fifo_user user (.clk_sys_i(clk), .rd_data_i(b_data_o), .wr_clk_en_o(wce),
      .wr_en_o(wen), .wr_data_o(u_wdata), .rd_clk_en_o(read_clock_enable), .pop_o(pop));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic [8:0] exp_flags(input int fill);
      return {5'h0, fill >= full_lvl, fill >= af_lvl, fill <= ae_lvl, fill == 0};
   endfunction

   // One RAM access on port A or B; returns in the cycle where the answer stands.
   task automatic ram(input logic b, input logic we, input logic [1:0] md,
                      input logic [9:0] ad, input logic [8:0] d);
      @(posedge clk);
      if (b) begin
         ce_b   <= 1'b1;
         we_b   <= we;
         mode_b <= md;
         ad_b   <= ad;
         dat_b  <= d;
      end else begin
         ce_a   <= 1'b1;
         we_a   <= we;
         mode_a <= md;
         ad_a   <= ad;
         dat_a  <= d;
      end
      @(posedge clk);
      ce_a  <= 1'b0;
      ce_b  <= 1'b0;
      dat_a <= ~d;
      dat_b <= ~d;
      @(posedge clk);
      #1;
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // The whole run needs well under a thousand cycles.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      seed = 32'h9551;
      {rstn, fifo, oreg, ce_a, we_a, ce_b, we_b, pa_rst, pb_rst} = 9'h0;
      {mode_a, mode_b} = 4'h0;
      {ad_a, ad_b, adr} = 30'h0;
      {dat_a, dat_b} = 18'h0;
      fail_count = 0;
      n_checks = 0;
      gsr_n = 1'b1;
      full_lvl = 10'h4;
      af_lvl = 10'h3;
      ae_lvl = 10'h1;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         adr = 10'($random(seed));
         v0 = 9'($random(seed));
         v1 = ~v0;
         v2 = 9'($random(seed));
         ram(1'b0, 1'b1, 2'h1, adr ^ 10'h1, v2);
         chk("through", v2, a_data_o);
         ram(1'b0, 1'b1, 2'h1, adr, v0);
         ram(1'b0, 1'b0, 2'h1, adr ^ 10'h1, 9'h0);
         chk("read", v2, a_data_o);
         ram(1'b0, 1'b1, 2'(m), adr, v1);
         chk("wmode", m == 0 ? v2 : (m == 1 ? v1 : v0), a_data_o);
         ram(1'b1, 1'b0, 2'h0, adr, 9'h0);
         chk("b_read", v1, b_data_o);
         ram(1'b1, 1'b1, 2'h2, adr ^ 10'h1, v0);
         chk("b_rbw", v2, b_data_o);
      end
      // With the output register on, a read shows up one edge later than without it.
      @(posedge clk);
      oreg <= 1'b1;
      ram(1'b0, 1'b0, 2'h0, adr, 9'h0);
      chk("reg_lag", v0, a_data_o);
      @(posedge clk);
      #1 chk("reg_out", v1, a_data_o);
      $display("test ram_modes done");
      @(posedge clk);
      oreg <= 1'b0;
      pa_rst <= 1'b1;
      #1 chk("a_clear", 9'h0, a_data_o);
      chk("b_keep", v2, b_data_o);
      @(posedge clk);
      pa_rst <= 1'b0;
      gsr_n <= 1'b0;
      #1 chk("gsr_b", 9'h0, b_data_o);
      chk("gsr_a", 9'h0, a_data_o);
      @(posedge clk);
      gsr_n <= 1'b1;
      $display("test clears done");
      fifo <= 1'b1;
      ae_lvl <= 10'(($random(seed) & 1) + 1);
      af_lvl <= 10'(($random(seed) & 1) + 2);
      for (int k = 0; k < 6; k++) begin
         dat[k] = 9'($random(seed));
         user.tx_q.push_back(dat[k]);
      end
      for (int k = 1; k <= 6; k++) begin
         @(posedge clk);
         user.send(1);
         @(posedge clk);
         #1 chk("flags", exp_flags(k > 4 ? 4 : k), {5'h0, ff, af, ae, ef});
      end
      @(posedge clk);
      user.take(5);
      for (int k = 0; k < 4; k++) chk("pop", dat[k], user.rx_q[k]);
      chk("pop_empty", dat[3], user.rx_q[4]);
      @(posedge clk);
      #1 chk("drained", exp_flags(0), {5'h0, ff, af, ae, ef});
      $display("test fifo_flags done");
      user.tx_q.push_back(9'h0ff);
      user.tx_q.push_back(9'h100);
      @(posedge clk);
      user.send(2);
      @(posedge clk);
      pa_rst <= 1'b1;
      @(posedge clk);
      pa_rst <= 1'b0;
      @(posedge clk);
      #1 chk("global_rst", exp_flags(0), {5'h0, ff, af, ae, ef});
      user.rx_q.delete();
      for (int k = 0; k < 3; k++) begin
         dat[k] = 9'($random(seed));
         user.tx_q.push_back(dat[k]);
      end
      @(posedge clk);
      user.send(3);
      @(posedge clk);
      user.take(3);
      @(posedge clk);
      pb_rst <= 1'b1;
      @(posedge clk);
      pb_rst <= 1'b0;
      @(posedge clk);
      user.take(3);
      for (int k = 0; k < 3; k++) chk("first", dat[k], user.rx_q[k]);
      for (int k = 0; k < 3; k++) chk("retransmit", dat[k], user.rx_q[k + 3]);
      $display("test retransmit done");
      close_out();
   end
endmodule
